// ---- hdl/cifm_edge_sync.sv ----
// two-flop synchroniser and rising-edge detector for the input pins
`timescale 1ns/10ps
module cifm_edge_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// pins and edges
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] rise_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] rise;
	} cifm_sync_s;
	cifm_sync_s q, d;
	always_comb begin
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.rise = q.s2 & ~q.s3;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign rise_out = q.rise;
endmodule

// ---- hdl/cifm_gate_timer.sv ----
// gate period timer for the frequency meter
`timescale 1ns/10ps
module cifm_gate_timer #(
	parameter int SHORT_CYC = cifm_pkg::GATE_SHORT_CYC,
	parameter int MID_CYC = cifm_pkg::GATE_MID_CYC,
	parameter int LONG_CYC = cifm_pkg::GATE_LONG_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic run_in,
	input wire logic [1:0] sel_in,
	// period end pulse
	output logic period_end_out
);
	localparam int CW = cifm_pkg::GATE_CNT_W;
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic done;
	} cifm_gate_s;
	cifm_gate_s q, d;
	function automatic logic [CW-1:0] gate_last(input logic [1:0] sel);
		case (sel)
			cifm_pkg::GATE_SEL_SHORT: gate_last = CW'(SHORT_CYC - 1);
			cifm_pkg::GATE_SEL_LONG: gate_last = CW'(LONG_CYC - 1);
			default: gate_last = CW'(MID_CYC - 1);
		endcase
	endfunction
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (!run_in) begin
			d.cnt = '0;
		end else if (q.cnt >= gate_last(sel_in)) begin
			// next period starts at once
			d.cnt = '0;
			d.done = 1'b1;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign period_end_out = q.done;
endmodule

// ---- hdl/cifm_pkg.sv ----
// shared constants for the counter interrupt and frequency meter block
package cifm_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int NUM_CNT = 3;
	localparam int CNT_W = 16;
	localparam int FREQ_W = 24;
	localparam int TS_W = 32;
	localparam int IRQ_W = 2;
	localparam int CTRL_W = 3;
	localparam int GATE_CNT_W = 27;
	// clock and gate lengths
	localparam int CLK_HZ = 10_000_000;
	localparam int MS_PER_S = 1000;
	localparam int GATE_SHORT_MS = 100;
	localparam int GATE_MID_MS = 1000;
	localparam int GATE_LONG_MS = 10000;
	localparam int GATE_SHORT_CYC = GATE_SHORT_MS * (CLK_HZ / MS_PER_S);
	localparam int GATE_MID_CYC = GATE_MID_MS * (CLK_HZ / MS_PER_S);
	localparam int GATE_LONG_CYC = GATE_LONG_MS * (CLK_HZ / MS_PER_S);
	localparam logic [1:0] GATE_SEL_SHORT = 2'h0;
	localparam logic [1:0] GATE_SEL_MID = 2'h1;
	localparam logic [1:0] GATE_SEL_LONG = 2'h2;
	localparam logic [1:0] GATE_SEL_BAD = 2'h3;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PRESET0 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_COUNT0 = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_FREQ_CFG = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_FREQ_CNT = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RUN = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_MOD_ADDR = 8'h3c;
	localparam logic [ADDR_W-1:0] OFS_REC0 = 8'h40;
	localparam int REC_WORDS = 5;
	// field positions
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_DOWN_BIT = 1;
	localparam int CTRL_IRQ_BIT = 2;
	localparam int CTRL_LOAD_BIT = 3;
	localparam int FCFG_EN_BIT = 2;
	localparam int IRQ_REC_BIT = 0;
	localparam int IRQ_FREQ_BIT = 1;
	localparam int FREQ_INPUT = 2;
	// reset and fixed values
	localparam logic [15:0] MOD_ADDR_RST = 16'h0110;
	localparam logic [15:0] SPARE_INFO = 16'h0110;
	localparam logic [FREQ_W-1:0] FREQ_RST = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	// event record header bytes, plain defaults
	localparam logic [7:0] REC_CLASS = 8'h11;
	localparam logic [7:0] REC_EVT_NUM = 8'h01;
	localparam logic [7:0] REC_PRIO = 8'h10;
	localparam logic [7:0] REC_HANDLER = 8'h01;
	localparam logic [7:0] REC_ID_INFO23 = 8'h54;
	localparam logic [7:0] REC_ID_INFO1 = 8'h58;
endpackage

// ---- hdl/cifm_top.sv ----
// counters with interrupt event records and a gated frequency meter
// What this block does
// - only irq-enabled counters raise interrupts
// - up counter interrupts at comparison value
// - down counter interrupts passing through zero
// - each counter interrupt comes with an event record
// - record is twenty bytes with header fields
// - bytes 6/7 carry module start address
// - byte 8 names triggering input
// - bytes 10/11 always read 0110 hex
// - input 3 counts rising edges per gate
// - gate is 0.1 s, 1 s or 10 s
// - latch count, restart next period at once
// - raw count reported, software divides
// - meter starts with run, no start command
// - all-ones reported until first period ends
// - after stop, last count kept until new
// - hit reinitialises counter, up or down
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/10ps
module cifm_top #(
	parameter int GATE_SHORT_CYC = cifm_pkg::GATE_SHORT_CYC,
	parameter int GATE_MID_CYC = cifm_pkg::GATE_MID_CYC,
	parameter int GATE_LONG_CYC = cifm_pkg::GATE_LONG_CYC
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// universal input pins
	input wire logic [cifm_pkg::NUM_CNT-1:0] pulse_in,
	// register port
	input wire logic [cifm_pkg::ADDR_W-1:0] addr_in,
	input wire logic [cifm_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	output logic [cifm_pkg::DATA_W-1:0] rd_data_out,
	// interrupt
	output logic irq_out
);
	localparam int N = cifm_pkg::NUM_CNT;
	localparam int CW = cifm_pkg::CNT_W;
	localparam int FW = cifm_pkg::FREQ_W;
	localparam int DW = cifm_pkg::DATA_W;
	localparam int AW = cifm_pkg::ADDR_W;
	localparam int IW = cifm_pkg::IRQ_W;
	localparam int TW = cifm_pkg::TS_W;

	typedef struct packed {
		logic [N-1:0][cifm_pkg::CTRL_W-1:0] ctrl;
		logic [N-1:0][CW-1:0] preset;
		logic [N-1:0][CW-1:0] count;
		logic [N-1:0] pend;
		logic [1:0] gate_sel;
		logic freq_en;
		logic sys_run;
		logic [FW-1:0] edge_cnt;
		logic [FW-1:0] freq;
		logic [IW-1:0] stat;
		logic [IW-1:0] irq_en;
		logic [15:0] mod_addr;
		logic rec_valid;
		logic [7:0] rec_input;
		logic [TW-1:0] rec_ts;
		logic [TW-1:0] ts;
		logic [DW-1:0] rdata;
	} cifm_state_s;

	cifm_state_s q, d;
	logic [N-1:0] rise;
	logic period_end;
	logic gate_run;
	logic [N-1:0] hit;

	function automatic logic [AW-1:0] reg_ofs(input logic [AW-1:0] base,
		input int idx);
		reg_ofs = base + AW'(idx * 4);
	endfunction

	function automatic logic [FW-1:0] sat_inc(input logic [FW-1:0] v);
		sat_inc = (v == cifm_pkg::FREQ_RST) ? v : v + 1'b1;
	endfunction

	function automatic logic [DW-1:0] rec_word(input cifm_state_s s,
		input int idx);
		case (idx)
			0: rec_word = {cifm_pkg::REC_HANDLER, cifm_pkg::REC_PRIO,
				cifm_pkg::REC_EVT_NUM, cifm_pkg::REC_CLASS};
			1: rec_word = {s.mod_addr[7:0], s.mod_addr[15:8],
				cifm_pkg::REC_ID_INFO1, cifm_pkg::REC_ID_INFO23};
			2: rec_word = {cifm_pkg::SPARE_INFO[7:0],
				cifm_pkg::SPARE_INFO[15:8], 8'h00, s.rec_input};
			3: rec_word = s.rec_ts;
			default: rec_word = '0;
		endcase
	endfunction

	cifm_edge_sync #(
		.W(N)
	) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.pin_in(pulse_in),
		.rise_out(rise)
	);

	// meter runs only while the cpu cycles and input 3 is a meter
	assign gate_run = q.sys_run && q.freq_en;

	cifm_gate_timer #(
		.SHORT_CYC(GATE_SHORT_CYC),
		.MID_CYC(GATE_MID_CYC),
		.LONG_CYC(GATE_LONG_CYC)
	) u_gate (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(gate_run),
		.sel_in(q.gate_sel),
		.period_end_out(period_end)
	);

	always_comb begin
		logic found;
		logic up_edge;
		found = 1'b0;
		up_edge = 1'b0;
		d = q;
		d.rdata = '0;
		d.ts = q.ts + 1'b1;
		hit = '0;
		// clears act first so that hardware sets below win
		if (wr_strobe_in && addr_in == cifm_pkg::OFS_IRQ_CLR) begin
			d.stat = q.stat & ~wr_data_in[IW-1:0];
			if (wr_data_in[cifm_pkg::IRQ_REC_BIT]) begin
				d.rec_valid = 1'b0;
			end
		end
		// one record at a time; further events wait in pend
		if (!q.rec_valid) begin
			for (int i = 0; i < N; i++) begin
				if (q.pend[i] && !found) begin
					found = 1'b1;
					d.pend[i] = 1'b0;
					d.rec_valid = 1'b1;
					d.rec_input = 8'(i + 1);
					d.rec_ts = q.ts;
					d.stat[cifm_pkg::IRQ_REC_BIT] = 1'b1;
				end
			end
		end
		for (int i = 0; i < N; i++) begin
			up_edge = rise[i] && q.ctrl[i][cifm_pkg::CTRL_RUN_BIT] &&
				!(i == cifm_pkg::FREQ_INPUT && q.freq_en);
			if (wr_strobe_in && addr_in == reg_ofs(cifm_pkg::OFS_CTRL0, i)
				&& wr_data_in[cifm_pkg::CTRL_LOAD_BIT]) begin
				d.count[i] = q.ctrl[i][cifm_pkg::CTRL_DOWN_BIT] ?
					q.preset[i] : '0;
			end else if (up_edge) begin
				if (!q.ctrl[i][cifm_pkg::CTRL_DOWN_BIT]) begin
					if (q.count[i] + cifm_pkg::CNT_ONE == q.preset[i]) begin
						d.count[i] = '0;
						hit[i] = 1'b1;
					end else begin
						d.count[i] = q.count[i] + 1'b1;
					end
				end else if (q.count[i] == cifm_pkg::CNT_ONE) begin
					d.count[i] = q.preset[i];
					hit[i] = 1'b1;
				end else if (q.count[i] == '0) begin
					d.count[i] = q.preset[i];
				end else begin
					d.count[i] = q.count[i] - 1'b1;
				end
			end
			if (hit[i] && q.ctrl[i][cifm_pkg::CTRL_IRQ_BIT]) begin
				d.pend[i] = 1'b1;
			end
		end
		// raw count only; software divides by the gate length
		if (period_end) begin
			d.freq = rise[cifm_pkg::FREQ_INPUT] ?
				sat_inc(q.edge_cnt) : q.edge_cnt;
			d.edge_cnt = '0;
			d.stat[cifm_pkg::IRQ_FREQ_BIT] = 1'b1;
		end else if (!gate_run) begin
			d.edge_cnt = '0;
		end else if (rise[cifm_pkg::FREQ_INPUT]) begin
			d.edge_cnt = sat_inc(q.edge_cnt);
		end
		if (wr_strobe_in) begin
			for (int i = 0; i < N; i++) begin
				if (addr_in == reg_ofs(cifm_pkg::OFS_CTRL0, i)) begin
					d.ctrl[i] = wr_data_in[cifm_pkg::CTRL_W-1:0];
				end
				if (addr_in == reg_ofs(cifm_pkg::OFS_PRESET0, i)) begin
					d.preset[i] = wr_data_in[CW-1:0];
				end
			end
			case (addr_in)
				cifm_pkg::OFS_FREQ_CFG: begin
					// the unused fourth code keeps the old gate
					if (wr_data_in[1:0] != cifm_pkg::GATE_SEL_BAD) begin
						d.gate_sel = wr_data_in[1:0];
					end
					d.freq_en = wr_data_in[cifm_pkg::FCFG_EN_BIT];
				end
				cifm_pkg::OFS_IRQ_EN: d.irq_en = wr_data_in[IW-1:0];
				cifm_pkg::OFS_RUN: d.sys_run = wr_data_in[0];
				cifm_pkg::OFS_MOD_ADDR: d.mod_addr = wr_data_in[15:0];
				default: begin
				end
			endcase
		end
		if (rd_strobe_in) begin
			for (int i = 0; i < N; i++) begin
				if (addr_in == reg_ofs(cifm_pkg::OFS_CTRL0, i)) begin
					d.rdata = DW'(q.ctrl[i]);
				end
				if (addr_in == reg_ofs(cifm_pkg::OFS_PRESET0, i)) begin
					d.rdata = DW'(q.preset[i]);
				end
				if (addr_in == reg_ofs(cifm_pkg::OFS_COUNT0, i)) begin
					d.rdata = DW'(q.count[i]);
				end
			end
			for (int i = 0; i < cifm_pkg::REC_WORDS; i++) begin
				if (addr_in == reg_ofs(cifm_pkg::OFS_REC0, i)) begin
					d.rdata = rec_word(q, i);
				end
			end
			case (addr_in)
				cifm_pkg::OFS_FREQ_CFG: d.rdata = DW'({q.freq_en, q.gate_sel});
				cifm_pkg::OFS_FREQ_CNT: d.rdata = DW'(q.freq);
				cifm_pkg::OFS_IRQ_STAT: d.rdata = DW'(q.stat);
				cifm_pkg::OFS_IRQ_EN: d.rdata = DW'(q.irq_en);
				cifm_pkg::OFS_RUN: d.rdata = DW'(q.sys_run);
				cifm_pkg::OFS_MOD_ADDR: d.rdata = DW'(q.mod_addr);
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.freq <= cifm_pkg::FREQ_RST;
			q.mod_addr <= cifm_pkg::MOD_ADDR_RST;
			q.gate_sel <= cifm_pkg::GATE_SEL_MID;
		end else begin
			q <= d;
		end
	end

	assign rd_data_out = q.rdata;
	assign irq_out = |(q.stat & q.irq_en);

	// checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence up_hit_s;
		rise[0] && q.ctrl[0][cifm_pkg::CTRL_RUN_BIT] &&
			!q.ctrl[0][cifm_pkg::CTRL_DOWN_BIT] &&
			q.ctrl[0][cifm_pkg::CTRL_IRQ_BIT] &&
			q.count[0] + cifm_pkg::CNT_ONE == q.preset[0] &&
			!wr_strobe_in;
	endsequence
	sequence down_hit_s;
		rise[0] && q.ctrl[0][cifm_pkg::CTRL_RUN_BIT] &&
			q.ctrl[0][cifm_pkg::CTRL_DOWN_BIT] &&
			q.ctrl[0][cifm_pkg::CTRL_IRQ_BIT] &&
			q.count[0] == cifm_pkg::CNT_ONE && !wr_strobe_in;
	endsequence
	sequence record_out_s;
		q.rec_valid && q.stat[cifm_pkg::IRQ_REC_BIT];
	endsequence
	// saturated counts are left out, they must not wrap
	sequence meter_edge_s;
		gate_run && !period_end && rise[cifm_pkg::FREQ_INPUT] &&
			q.edge_cnt != cifm_pkg::FREQ_RST;
	endsequence

	a_up_hit_event: assert property (up_hit_s |=>
		q.count[0] == '0 && (q.pend[0] || q.rec_valid))
		else $error("up hit did not reinit or flag");
	a_down_zero_event: assert property (down_hit_s |=>
		q.count[0] == $past(q.preset[0]) && (q.pend[0] || q.rec_valid))
		else $error("down zero did not reload or flag");
	a_load_up_zero: assert property (
		wr_strobe_in && addr_in == cifm_pkg::OFS_CTRL0 &&
		wr_data_in[cifm_pkg::CTRL_LOAD_BIT] &&
		!q.ctrl[0][cifm_pkg::CTRL_DOWN_BIT] |=> q.count[0] == '0)
		else $error("up load did not clear count");
	a_disabled_quiet: assert property (
		!q.ctrl[1][cifm_pkg::CTRL_IRQ_BIT] && !q.pend[1] |=> !q.pend[1])
		else $error("pend set without irq enable");
	a_record_load: assert property (!q.rec_valid && |q.pend |=>
		record_out_s ##0 q.rec_input != 8'h00)
		else $error("pending event not recorded");
	a_record_order: assert property (
		!q.rec_valid && q.pend[0] |=> q.rec_input == 8'h01)
		else $error("lowest input not recorded first");
	a_record_stands: assert property (
		q.rec_valid && !wr_strobe_in |=> q.rec_valid &&
		$stable(q.rec_input) && $stable(q.rec_ts))
		else $error("record changed before clear");
	a_clear_record: assert property (q.rec_valid && wr_strobe_in &&
		addr_in == cifm_pkg::OFS_IRQ_CLR &&
		wr_data_in[cifm_pkg::IRQ_REC_BIT] |=> !q.rec_valid)
		else $error("record not released by clear");
	a_record_irq: assert property (record_out_s ##0
		q.irq_en[cifm_pkg::IRQ_REC_BIT] |-> irq_out)
		else $error("record without interrupt");
	a_record_input: assert property (q.rec_valid |->
		q.rec_input != 8'h00 && q.rec_input <= 8'(N))
		else $error("record names no valid input");
	a_spare_word: assert property (rd_strobe_in &&
		addr_in == cifm_pkg::OFS_REC0 + 8'h08 |=>
		rd_data_out[31:16] == 16'h1001)
		else $error("spare info word wrong");
	a_meter_edge: assert property (meter_edge_s |=>
		q.edge_cnt == $past(q.edge_cnt) + 1'b1)
		else $error("meter edge not counted");
	a_meter_owns_input: assert property (
		q.freq_en && !wr_strobe_in |=>
		$stable(q.count[cifm_pkg::FREQ_INPUT]))
		else $error("counter moved while input is a meter");
	a_gate_sel_legal: assert property (
		q.gate_sel != cifm_pkg::GATE_SEL_BAD)
		else $error("unused gate code accepted");
	a_freq_latch: assert property (period_end &&
		!rise[cifm_pkg::FREQ_INPUT] |=>
		q.freq == $past(q.edge_cnt) && q.edge_cnt == '0)
		else $error("freq count not latched");
	a_period_flag: assert property (period_end |=>
		q.stat[cifm_pkg::IRQ_FREQ_BIT])
		else $error("period end not flagged");
	a_meter_restart: assert property ($rose(gate_run) |->
		q.edge_cnt == '0)
		else $error("meter restarted with stale edges");
	a_ones_until_first: assert property (
		q.freq == cifm_pkg::FREQ_RST && !period_end |=>
		q.freq == cifm_pkg::FREQ_RST)
		else $error("all-ones count left early");
	a_freq_hold: assert property (!period_end |=> $stable(q.freq))
		else $error("freq count changed mid period");
	a_stop_clear: assert property (!gate_run |=> q.edge_cnt == '0)
		else $error("edge count kept while stopped");
	a_read_slot: assert property (!rd_strobe_in |=> rd_data_out == '0)
		else $error("read data outside slot");
endmodule

// ---- tb/cifm_pulse_src.sv ----
// transducer model driving the three universal input pins
`timescale 1ns/10ps
module cifm_pulse_src #(
	parameter int HALF_NS = 50000
) (
	// channel enables from the bench
	input wire logic [2:0] en_in,
	// pins toward the block
	output logic [2:0] pin_out
);
	// idle low; a 50 us half period keeps each channel at 10 kHz
	// the odd start offset keeps pin changes off the clock edges
	initial begin
		pin_out = 3'h0;
		#30;
		forever begin
			#(HALF_NS);
			pin_out = en_in & ~pin_out;
		end
	end
endmodule

// ---- tb/cifm_top_test.sv ----
// self-checking bench for the counter interrupt and frequency meter
`timescale 1ns/10ps
module cifm_top_test;
	// short gates keep the run small; pulses stay at the 10 kHz limit
	localparam int G0 = 2000;
	localparam int G1 = 4000;
	localparam int G2 = 8000;
	localparam int PULSE_CYC = 1000;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [2:0] pulse_in;
	logic [2:0] en = 3'h0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0;
	logic wr_strobe_in = 1'b0;
	logic rd_strobe_in = 1'b0;
	logic [31:0] rd_data_out;
	logic irq_out;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] m;
	int gates[3] = '{G0, G1, G2};
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	int p;

	always #50 clk_in = ~clk_in;

	cifm_top #(
		.GATE_SHORT_CYC(G0),
		.GATE_MID_CYC(G1),
		.GATE_LONG_CYC(G2)
	) cifm_top_inst (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.pulse_in(pulse_in),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_strobe_in(wr_strobe_in),
		.rd_strobe_in(rd_strobe_in),
		.rd_data_out(rd_data_out),
		.irq_out(irq_out)
	);

	cifm_pulse_src cifm_pulse_src_inst (
		.en_in(en),
		.pin_out(pulse_in)
	);

	task automatic end_sim();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic fail(input string s);
		mismatches++;
		$display("FAIL %0t %s", $time, s);
	endtask

	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e);
		cmp_count++;
		if (got !== e)
			fail($sformatf("read %h expected %h", got, e));
	endtask

	// level is looked at mid-cycle, after register updates have landed
	task automatic chk_irq(input logic e);
		@(negedge clk_in);
		cmp_count++;
		if (irq_out !== e)
			fail("interrupt level");
	endtask

	// one strobe cycle; a read leaves its expected word in the queue
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		wr_strobe_in <= w;
		rd_strobe_in <= ~w;
		addr_in <= a;
		wr_data_in <= d;
		if (!w)
			exp_q.push_back(d);
		@(posedge clk_in);
		wr_strobe_in <= 1'b0;
		rd_strobe_in <= 1'b0;
	endtask

	// only one channel is enabled during counter tests; a change counts when it leaves that pin high
	task automatic pulses(input int ch, input int k);
		en[ch] = 1'b1;
		while (k > 0) begin
			@(pulse_in);
			if (pulse_in[ch])
				k--;
		end
		en[ch] = 1'b0;
		repeat (20) @(posedge clk_in);
	endtask

	// polled mid-cycle so a clear landing on this edge is already seen
	task automatic wait_irq();
		int n = 0;
		@(negedge clk_in);
		while (irq_out !== 1'b1 && n < 30000) begin
			@(negedge clk_in);
			n++;
		end
		if (irq_out !== 1'b1)
			fail("no interrupt");
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (rd_seen) begin
			if (exp_q.size() == 0)
				fail("read without note");
			else
				cmp_rd(rd_data_out, exp_q.pop_front());
		end
		rd_seen <= rd_strobe_in;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail("timeout");
			end_sim();
		end
	end

	initial begin
		void'($urandom(32'hc8282198));
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		bus(0, cifm_pkg::OFS_FREQ_CFG, 32'h1);
		bus(0, cifm_pkg::OFS_FREQ_CNT, 32'hffffff);
		bus(0, cifm_pkg::OFS_MOD_ADDR, 32'h110);
		bus(0, cifm_pkg::OFS_IRQ_STAT, 32'h0);
		bus(0, 8'hfc, 32'h0);
		chk_irq(1'b0);
		$display("test reset values done");
		p = 2 + int'($urandom % 3);
		bus(1, cifm_pkg::OFS_PRESET0, 32'(p));
		bus(1, cifm_pkg::OFS_CTRL0, 32'hd);
		pulses(0, p - 1);
		bus(0, cifm_pkg::OFS_IRQ_STAT, 32'h0);
		pulses(0, 1);
		chk_irq(1'b0);
		bus(0, cifm_pkg::OFS_IRQ_STAT, 32'h1);
		bus(1, cifm_pkg::OFS_IRQ_EN, 32'h1);
		chk_irq(1'b1);
		bus(0, cifm_pkg::OFS_REC0, 32'h01100111);
		bus(0, cifm_pkg::OFS_REC0 + 8'h4, 32'h10015854);
		bus(0, cifm_pkg::OFS_REC0 + 8'h8, 32'h10010001);
		bus(0, cifm_pkg::OFS_REC0 + 8'h10, 32'h0);
		bus(0, cifm_pkg::OFS_COUNT0, 32'h0);
		bus(1, cifm_pkg::OFS_IRQ_CLR, 32'h1);
		chk_irq(1'b0);
		bus(0, cifm_pkg::OFS_IRQ_STAT, 32'h0);
		$display("test up counter done");
		m = $urandom & 32'hffff;
		bus(1, cifm_pkg::OFS_MOD_ADDR, m);
		bus(1, cifm_pkg::OFS_CTRL0 + 8'h4, 32'h2);
		bus(1, cifm_pkg::OFS_PRESET0 + 8'h4, 32'h2);
		bus(1, cifm_pkg::OFS_CTRL0 + 8'h4, 32'hf);
		pulses(1, 1);
		chk_irq(1'b0);
		pulses(1, 1);
		chk_irq(1'b1);
		bus(0, cifm_pkg::OFS_REC0 + 8'h4, {m[7:0], m[15:8], 16'h5854});
		bus(0, cifm_pkg::OFS_REC0 + 8'h8, 32'h10010002);
		bus(0, cifm_pkg::OFS_COUNT0 + 8'h4, 32'h2);
		bus(1, cifm_pkg::OFS_IRQ_CLR, 32'h1);
		chk_irq(1'b0);
		$display("test down counter done");
		bus(1, cifm_pkg::OFS_PRESET0 + 8'h8, 32'h1);
		bus(1, cifm_pkg::OFS_CTRL0 + 8'h8, 32'h1);
		pulses(2, 2);
		chk_irq(1'b0);
		bus(0, cifm_pkg::OFS_IRQ_STAT, 32'h0);
		$display("test disabled interrupt done");
		bus(1, cifm_pkg::OFS_IRQ_EN, 32'h2);
		bus(1, cifm_pkg::OFS_FREQ_CFG, 32'h4);
		en[2] = 1'b1;
		bus(1, cifm_pkg::OFS_RUN, 32'h1);
		bus(0, cifm_pkg::OFS_FREQ_CNT, 32'hffffff);
		// the first period after a change may be partial, so use the second
		for (int s = 0; s < 3; s++) begin
			bus(1, cifm_pkg::OFS_FREQ_CFG, 32'h4 | 32'(s));
			repeat (2) begin
				bus(1, cifm_pkg::OFS_IRQ_CLR, 32'h2);
				wait_irq();
			end
			bus(0, cifm_pkg::OFS_FREQ_CNT, 32'(gates[s] / PULSE_CYC));
		end
		bus(1, cifm_pkg::OFS_FREQ_CFG, 32'h7);
		bus(0, cifm_pkg::OFS_FREQ_CFG, 32'h6);
		$display("test frequency gates done");
		bus(1, cifm_pkg::OFS_RUN, 32'h0);
		en[2] = 1'b0;
		repeat (G2 + 1000) @(posedge clk_in);
		bus(0, cifm_pkg::OFS_FREQ_CNT, 32'h8);
		bus(1, cifm_pkg::OFS_IRQ_CLR, 32'h2);
		bus(1, cifm_pkg::OFS_RUN, 32'h1);
		bus(0, cifm_pkg::OFS_FREQ_CNT, 32'h8);
		wait_irq();
		bus(0, cifm_pkg::OFS_FREQ_CNT, 32'h0);
		$display("test stop and restart done");
		end_sim();
	end
endmodule
